/* shared/esfc_defines.svh */
// constants of the event status and frequency control block
`ifndef ESFC_DEFINES_SVH
`define ESFC_DEFINES_SVH

// ----------------------------------------------------------------------------
// register geometry
// ----------------------------------------------------------------------------
`define ESR_COUNT        4
`define ESR_WIDTH        8
`define ESR_RESET        8'h00
`define ESE_RESET        8'h00
`define ESR_MAX          32'h000000FF

// ----------------------------------------------------------------------------
// number handling
// ----------------------------------------------------------------------------
`define SIG_MIN          32'h000186A0
`define SIG_MAX          32'h000F4240
`define ROUND_HALF       33'h000000005
`define DEC_BASE33       33'h00000000A
`define DEC_BASE32       32'h0000000A
`define EXP_ONE          8'sh01
`define EXP_ZERO         8'sh00
`define EXP_1K           8'shFE
`define EXP_100K         8'sh00
`define EXP_1M           8'sh01
`define DEC_HUNDRED      8'h64
`define DEC_TEN          8'h0A
`define DIG_FIRST        2'h0
`define DIG_MID          2'h1
`define DIG_LAST         2'h2

// ----------------------------------------------------------------------------
// response text
// ----------------------------------------------------------------------------
`define ASCII_ZERO       8'h30
`define ASCII_LF         8'h0A
`define TXT_END          8'h00
`define TXT_LEN          73
`define TXT_AW           7
`define TXT_FREQ_HDR     7'h00
`define TXT_F1K          7'h0C
`define TXT_F100K        7'h17
`define TXT_F1M          7'h22
`define TXT_ESE_HDR      7'h2D
`define TXT_ESE_STRIDE   7'h07
`define TXT_STEP         7'h01

`endif

/* shared/esfc_pkg.sv */
// types of the event status and frequency control block
package esfc_pkg;

  typedef enum logic [2:0] {
    CMD_ESR_QUERY  = 3'h0,
    CMD_ESE_SET    = 3'h1,
    CMD_ESE_QUERY  = 3'h2,
    CMD_FREQ_SET   = 3'h3,
    CMD_FREQ_QUERY = 3'h4,
    CMD_HEADER_SET = 3'h5
  } cmd_e;

  typedef enum logic [1:0] {
    FREQ_1K   = 2'h0,
    FREQ_100K = 2'h1,
    FREQ_1M   = 2'h2
  } freq_e;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_NORM  = 6'h02,
    ST_FETCH = 6'h04,
    ST_LOAD  = 6'h08,
    ST_DIGIT = 6'h10,
    ST_EOL   = 6'h20
  } state_e;

endpackage

/* shared/text_rom_if.sv */
// read port between the response engine and the text memory
interface text_rom_if;
  logic [6:0] addr;
  logic [7:0] q;
  modport client (output addr, input q);
  modport rom    (input addr, output q);
endinterface

/* hdl/text_rom.sv */
// fixed response text memory with registered read data
`include "esfc_defines.svh"
module text_rom (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // read port
  text_rom_if.rom  bus
);

  // strings end with a zero byte
  localparam logic [8*`TXT_LEN-1:0] TEXT = {
    ":FREQUENCY ", `TXT_END,
    "1.00000E+3",  `TXT_END,
    "100.000E+3",  `TXT_END,
    "1.00000E+6",  `TXT_END,
    ":ESE0 ",      `TXT_END,
    ":ESE1 ",      `TXT_END,
    ":ESE2 ",      `TXT_END,
    ":ESE3 ",      `TXT_END
  };

  logic [7:0] q_r;
  logic [7:0] q_nxt;

  always_comb begin
    q_nxt = `TXT_END;
    if (int'(bus.addr) < `TXT_LEN) begin
      q_nxt = TEXT[8*(`TXT_LEN-1-int'(bus.addr)) +: 8];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= `TXT_END;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign bus.q = q_r;

endmodule

/* hdl/event_status_frequency_ctl.sv */
// event status registers, enable masks, header option and measurement frequency
// What this block does
// - reading measurement events returns decimal 0..255, then clears the register
// - judgement events read as decimal then cleared; limit, pass, secondary, primary
// - bin group a read as decimal then cleared; bit n means bin n+1
// - bin group b read then cleared; bins 9..13, low capacitance, no bin, reject
// - event status answers never carry a header
// - frequency is 1 kHz, 100 kHz (one variant only) or 1 MHz
// - frequency argument in any notation, rounded to significant digits before storing
// - frequency query answers six digit exponent form, header only when enabled
// - each event register has an 8-bit enable mask, zero at power-on
// - response header option is off at power-on
`include "esfc_defines.svh"
module event_status_frequency_ctl #(
  parameter bit HAS_100K = 1'b1
) (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                rst_n,
  // parsed command port
  input  wire logic                cmd_valid,
  output      logic                cmd_ready,
  input  wire esfc_pkg::cmd_e      cmd_code,
  input  wire logic [1:0]          cmd_sel,
  input  wire logic [31:0]         cmd_mant,
  input  wire logic signed [7:0]   cmd_exp,
  output      logic                cmd_error,
  // response character stream
  output      logic                rsp_valid,
  input  wire logic                rsp_ready,
  output      logic [7:0]          rsp_data,
  // measurement events, one-cycle pulses
  input  wire logic [7:0]          meas_event,
  input  wire logic [7:0]          judge_event,
  input  wire logic [7:0]          bin_a_event,
  input  wire logic [7:0]          bin_b_event,
  // settings and summaries
  output      esfc_pkg::freq_e     freq_sel,
  output      logic                header_on,
  output      logic [3:0]          event_summary
);
  import esfc_pkg::*;

  // --------------------------------------------------------------------------
  // event status registers
  // --------------------------------------------------------------------------
  logic [7:0] ev       [`ESR_COUNT];
  logic [7:0] esr_r    [`ESR_COUNT];
  logic [7:0] esr_nxt  [`ESR_COUNT];
  logic [7:0] ese_r    [`ESR_COUNT];
  logic [7:0] ese_nxt  [`ESR_COUNT];
  logic [3:0] clr_esr;

  // bit order of each event vector is the register's bit order
  assign ev[0] = meas_event;
  assign ev[1] = judge_event;
  assign ev[2] = bin_a_event;
  assign ev[3] = bin_b_event;

  for (genvar g = 0; g < `ESR_COUNT; g++) begin : g_esr
    // a new event wins over the clear of the read
    always_comb begin
      esr_nxt[g] = (clr_esr[g] ? `ESR_RESET : esr_r[g]) | ev[g];
    end
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        esr_r[g] <= `ESR_RESET;
        ese_r[g] <= `ESE_RESET;
      end else begin
        esr_r[g] <= esr_nxt[g];
        ese_r[g] <= ese_nxt[g];
      end
    end
    assign event_summary[g] = |(esr_r[g] & ese_r[g]);
  end

  // --------------------------------------------------------------------------
  // text memory
  // --------------------------------------------------------------------------
  text_rom_if rom_bus ();

  text_rom u_text_rom (
    .mclk  (mclk),
    .rst_n (rst_n),
    .bus   (rom_bus.rom)
  );

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [1:0] first_digit(input logic [7:0] v);
    if (v >= `DEC_HUNDRED) begin
      return `DIG_FIRST;
    end else if (v >= `DEC_TEN) begin
      return `DIG_MID;
    end
    return `DIG_LAST;
  endfunction

  function automatic logic [7:0] digit_of(input logic [7:0] v, input logic [1:0] idx);
    case (idx)
      `DIG_FIRST: return v / `DEC_HUNDRED;
      `DIG_MID:   return (v / `DEC_TEN) % `DEC_TEN;
      default:    return v % `DEC_TEN;
    endcase
  endfunction

  function automatic logic [6:0] freq_text(input freq_e f);
    case (f)
      FREQ_100K: return `TXT_F100K;
      FREQ_1M:   return `TXT_F1M;
      default:   return `TXT_F1K;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // command and response engine
  // --------------------------------------------------------------------------
  state_e             st_r,    st_nxt;
  cmd_e               code_r,  code_nxt;
  logic [1:0]         sel_r,   sel_nxt;
  logic [31:0]        mant_r,  mant_nxt;
  logic signed [7:0]  exp_r,   exp_nxt;
  logic [7:0]         val_r,   val_nxt;
  logic [1:0]         didx_r,  didx_nxt;
  logic [6:0]         ptr_r,   ptr_nxt;
  logic               seg_r,   seg_nxt;
  logic [7:0]         out_r,   out_nxt;
  logic               vld_r,   vld_nxt;
  logic               err_r,   err_nxt;
  logic               hdr_r,   hdr_nxt;
  freq_e              freq_r,  freq_nxt;
  logic               can_load;

  assign can_load     = ~vld_r | rsp_ready;
  assign rom_bus.addr = ptr_r;

  always_comb begin
    st_nxt   = st_r;
    code_nxt = code_r;
    sel_nxt  = sel_r;
    mant_nxt = mant_r;
    exp_nxt  = exp_r;
    val_nxt  = val_r;
    didx_nxt = didx_r;
    ptr_nxt  = ptr_r;
    seg_nxt  = seg_r;
    out_nxt  = out_r;
    vld_nxt  = vld_r & ~rsp_ready;
    err_nxt  = 1'b0;
    hdr_nxt  = hdr_r;
    freq_nxt = freq_r;
    clr_esr  = 4'h0;
    for (int i = 0; i < `ESR_COUNT; i++) begin
      ese_nxt[i] = ese_r[i];
    end
    case (st_r)
      ST_IDLE: begin
        if (cmd_valid) begin
          code_nxt = cmd_code;
          sel_nxt  = cmd_sel;
          mant_nxt = cmd_mant;
          exp_nxt  = cmd_exp;
          seg_nxt  = 1'b0;
          case (cmd_code)
            CMD_ESR_QUERY: begin
              // snapshot then clear, bare value only
              val_nxt          = esr_r[cmd_sel];
              didx_nxt         = first_digit(esr_r[cmd_sel]);
              clr_esr[cmd_sel] = 1'b1;
              st_nxt           = ST_DIGIT;
            end
            CMD_ESE_QUERY: begin
              val_nxt  = ese_r[cmd_sel];
              didx_nxt = first_digit(ese_r[cmd_sel]);
              ptr_nxt  = `TXT_ESE_HDR + ({5'h00, cmd_sel} * `TXT_ESE_STRIDE);
              st_nxt   = hdr_r ? ST_FETCH : ST_DIGIT;
            end
            CMD_FREQ_QUERY: begin
              ptr_nxt = hdr_r ? `TXT_FREQ_HDR : freq_text(freq_r);
              seg_nxt = ~hdr_r;
              st_nxt  = ST_FETCH;
            end
            CMD_ESE_SET,
            CMD_FREQ_SET: begin
              st_nxt = ST_NORM;
            end
            CMD_HEADER_SET: begin
              hdr_nxt = (cmd_mant != 32'h00000000);
            end
            default: begin
              err_nxt = 1'b1;
            end
          endcase
        end
      end
      ST_NORM: begin
        if (code_r == CMD_FREQ_SET) begin
          // bring the mantissa to six digits, rounding half up
          if (mant_r == 32'h00000000) begin
            err_nxt = 1'b1;
            st_nxt  = ST_IDLE;
          end else if (mant_r >= `SIG_MAX) begin
            mant_nxt = 32'(({1'b0, mant_r} + `ROUND_HALF) / `DEC_BASE33);
            exp_nxt  = exp_r + `EXP_ONE;
          end else if (mant_r < `SIG_MIN) begin
            mant_nxt = 32'(mant_r * `DEC_BASE32);
            exp_nxt  = exp_r - `EXP_ONE;
          end else begin
            st_nxt = ST_IDLE;
            if (mant_r == `SIG_MIN && exp_r == `EXP_1K) begin
              freq_nxt = FREQ_1K;
            end else if (HAS_100K && mant_r == `SIG_MIN && exp_r == `EXP_100K) begin
              freq_nxt = FREQ_100K;
            end else if (mant_r == `SIG_MIN && exp_r == `EXP_1M) begin
              freq_nxt = FREQ_1M;
            end else begin
              err_nxt = 1'b1;
            end
          end
        end else begin
          // mask argument rounds to an integer
          if (exp_r < `EXP_ZERO) begin
            mant_nxt = 32'(({1'b0, mant_r} + `ROUND_HALF) / `DEC_BASE33);
            exp_nxt  = exp_r + `EXP_ONE;
          end else if (exp_r > `EXP_ZERO && mant_r <= `ESR_MAX) begin
            mant_nxt = 32'(mant_r * `DEC_BASE32);
            exp_nxt  = exp_r - `EXP_ONE;
          end else begin
            st_nxt = ST_IDLE;
            if (exp_r == `EXP_ZERO && mant_r <= `ESR_MAX) begin
              ese_nxt[sel_r] = mant_r[7:0];
            end else begin
              err_nxt = 1'b1;
            end
          end
        end
      end
      ST_FETCH: begin
        st_nxt = ST_LOAD;
      end
      ST_LOAD: begin
        if (rom_bus.q == `TXT_END) begin
          if (seg_r) begin
            st_nxt = ST_EOL;
          end else if (code_r == CMD_FREQ_QUERY) begin
            ptr_nxt = freq_text(freq_r);
            seg_nxt = 1'b1;
            st_nxt  = ST_FETCH;
          end else begin
            st_nxt = ST_DIGIT;
          end
        end else if (can_load) begin
          out_nxt = rom_bus.q;
          vld_nxt = 1'b1;
          ptr_nxt = ptr_r + `TXT_STEP;
          st_nxt  = ST_FETCH;
        end
      end
      ST_DIGIT: begin
        if (can_load) begin
          out_nxt = `ASCII_ZERO + digit_of(val_r, didx_r);
          vld_nxt = 1'b1;
          if (didx_r == `DIG_LAST) begin
            st_nxt = ST_EOL;
          end else begin
            didx_nxt = didx_r + 2'h1;
          end
        end
      end
      ST_EOL: begin
        if (can_load) begin
          out_nxt = `ASCII_LF;
          vld_nxt = 1'b1;
          st_nxt  = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r   <= ST_IDLE;
      code_r <= CMD_ESR_QUERY;
      sel_r  <= 2'h0;
      mant_r <= 32'h00000000;
      exp_r  <= `EXP_ZERO;
      val_r  <= 8'h00;
      didx_r <= `DIG_FIRST;
      ptr_r  <= `TXT_FREQ_HDR;
      seg_r  <= 1'b0;
      out_r  <= 8'h00;
      vld_r  <= 1'b0;
      err_r  <= 1'b0;
      hdr_r  <= 1'b0;
      freq_r <= FREQ_1K;
    end else begin
      st_r   <= st_nxt;
      code_r <= code_nxt;
      sel_r  <= sel_nxt;
      mant_r <= mant_nxt;
      exp_r  <= exp_nxt;
      val_r  <= val_nxt;
      didx_r <= didx_nxt;
      ptr_r  <= ptr_nxt;
      seg_r  <= seg_nxt;
      out_r  <= out_nxt;
      vld_r  <= vld_nxt;
      err_r  <= err_nxt;
      hdr_r  <= hdr_nxt;
      freq_r <= freq_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign cmd_ready = (st_r == ST_IDLE);
  assign cmd_error = err_r;
  assign rsp_valid = vld_r;
  assign rsp_data  = out_r;
  assign freq_sel  = freq_r;
  assign header_on = hdr_r;

endmodule

/* dv/esfc_checker.sv */
// port assertions for the event status and frequency block
module esfc_checker #(
  parameter bit HAS_100K = 1'b1
) (
  // clock and reset
  input wire logic               mclk,
  input wire logic               rst_n,
  // command and response
  input wire logic               cmd_valid,
  input wire logic               cmd_ready,
  input wire esfc_pkg::cmd_e     cmd_code,
  input wire logic               rsp_valid,
  input wire logic               rsp_ready,
  input wire logic [7:0]         rsp_data,
  // settings and summaries
  input wire esfc_pkg::freq_e    freq_sel,
  input wire logic               header_on,
  input wire logic [3:0]         event_summary
);
  timeunit 1ns;
  timeprecision 1ns;
  import esfc_pkg::*;
  logic stat_go;
  logic fq_go;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  assign stat_go = cmd_valid && cmd_ready && !rsp_valid && cmd_code == CMD_ESR_QUERY;
  assign fq_go   = cmd_valid && cmd_ready && !rsp_valid && cmd_code == CMD_FREQ_QUERY;
  // ----
  // assertions
  // ----
  a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
    else $error("response character changed before it was taken");
  a_stat_bare: assert property (stat_go |-> ##2 rsp_valid && rsp_data inside {[8'h30:8'h39]})
    else $error("status answer does not start with a digit");
  a_query_busy: assert property (stat_go || fq_go |=> !cmd_ready)
    else $error("engine idle right after a query");
  a_freq_text: assert property (fq_go && !header_on |=> !rsp_valid ##1 !rsp_valid ##1 rsp_valid && rsp_data == 8'h31)
    else $error("frequency answer wrong first character");
  a_freq_header: assert property (fq_go && header_on |-> ##3 rsp_valid && rsp_data == 8'h3A)
    else $error("frequency answer lacks its keyword");
  a_freq_legal: assert property (freq_sel == FREQ_1K || freq_sel == FREQ_1M || (HAS_100K && freq_sel == FREQ_100K))
    else $error("frequency setting outside the allowed set");
  a_reset_state: assert property ($rose(rst_n) |-> freq_sel == FREQ_1K && !header_on && event_summary == 4'h0)
    else $error("settings not at power-on values");
  a_event_sticky: assert property (cmd_ready && !cmd_valid |=> (event_summary & $past(event_summary)) == $past(event_summary))
    else $error("event bit lost without a read");
  c_stat_read: cover property (stat_go);
  c_freq_hdr: cover property (fq_go && header_on);
  c_stall: cover property (rsp_valid && !rsp_ready);
endmodule

bind event_status_frequency_ctl esfc_checker #(.HAS_100K(HAS_100K)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_code(cmd_code), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data),
  .freq_sel(freq_sel), .header_on(header_on), .event_summary(event_summary)
);

/* dv/host_sink.sv */
// host side model that receives response lines, promptly or with stalls
module host_sink (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // pace control
  input  wire logic         slow,
  // response stream
  input  wire logic         rsp_valid,
  input  wire logic [7:0]   rsp_data,
  output      logic         rsp_ready,
  // received lines
  output      logic [191:0] line,
  output      int           nlines
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [191:0] acc_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_ready <= 1'b0;
      acc_r     <= '0;
      line      <= '0;
      nlines    <= 0;
    end else begin
      rsp_ready <= slow ? ~rsp_ready : 1'b1;
      if (rsp_valid && rsp_ready) begin
        // line feed ends a line
        if (rsp_data == 8'h0A) begin
          line   <= acc_r;
          acc_r  <= '0;
          nlines <= nlines + 1;
        end else begin
          acc_r <= {acc_r[183:0], rsp_data};
        end
      end
    end
  end
endmodule

/* dv/event_status_frequency_ctl_tb.sv */
// self-checking bench for the event status and frequency block
module event_status_frequency_ctl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import esfc_pkg::*;
  logic              mclk = 1'b0;
  logic              rst_n = 1'b0;
  logic              slow = 1'b0;
  logic              cmd_valid = 1'b0;
  cmd_e              cmd_code = CMD_ESR_QUERY;
  logic [1:0]        cmd_sel = 2'h0;
  logic [31:0]       cmd_mant = 32'h0;
  logic signed [7:0] cmd_exp = 8'sh00;
  logic [7:0]        ev [4] = '{default: 8'h00};
  logic              cmd_ready, cmd_error, rsp_valid, rsp_ready, header_on;
  logic [7:0]        rsp_data;
  freq_e             freq_sel;
  logic [3:0]        event_summary;
  logic [191:0]      line;
  int                nlines, e0;
  int                errors = 0, n_tests = 0, cyc = 0, n_err = 0;
  logic [7:0]        vals [4] = '{8'h84, 8'h52, 8'h81, 8'hFF};
  logic [191:0]      txt [4] = '{"132", "82", "129", "255"};
  logic [31:0]       fm [5] = '{32'h1, 32'h186A0, 32'h989684, 32'h7D0, 32'hF4244};
  logic signed [7:0] fx [5] = '{8'sh06, 8'sh00, 8'shFC, 8'sh00, 8'sh00};
  freq_e             ff [5] = '{FREQ_1M, FREQ_100K, FREQ_1K, FREQ_1K, FREQ_1M};
  int                fe [5] = '{0, 0, 0, 1, 0};
  logic [191:0]      ft [5] = '{"1.00000E+6", "100.000E+3", "1.00000E+3", "1.00000E+3",
                                "1.00000E+6"};

  event_status_frequency_ctl #(.HAS_100K(1'b1)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_code(cmd_code), .cmd_sel(cmd_sel), .cmd_mant(cmd_mant), .cmd_exp(cmd_exp),
    .cmd_error(cmd_error), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_data(rsp_data), .meas_event(ev[0]), .judge_event(ev[1]), .bin_a_event(ev[2]),
    .bin_b_event(ev[3]), .freq_sel(freq_sel), .header_on(header_on),
    .event_summary(event_summary));
  host_sink u_host (
    .mclk(mclk), .rst_n(rst_n), .slow(slow), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_ready(rsp_ready), .line(line), .nlines(nlines));

  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cmd_error === 1'b1) n_err <= n_err + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      final_report();
    end
  end
  // ----
  // tasks
  // ----
  task automatic check(input logic [191:0] seen, input logic [191:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic send(input cmd_e c, input logic [1:0] s, input logic [31:0] m,
                      input logic signed [7:0] e);
    int i;
    @(posedge mclk);
    cmd_code  <= c;
    cmd_sel   <= s;
    cmd_mant  <= m;
    cmd_exp   <= e;
    cmd_valid <= 1'b1;
    do @(posedge mclk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (cmd_ready !== 1'b1 && i < 60);
    @(posedge mclk);
  endtask
  task automatic query(input cmd_e c, input logic [1:0] s, input logic [191:0] exp);
    int n0, i;
    n0 = nlines;
    send(c, s, 32'h0, 8'sh00);
    i = 0;
    while (nlines == n0 && i < 200) begin
      @(posedge mclk);
      i++;
    end
    check(line, exp);
  endtask
  task automatic pulse(input int g, input logic [7:0] v);
    @(posedge mclk);
    ev[g] <= v;
    @(posedge mclk);
    ev[g] <= 8'h00;
  endtask
  task final_report;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----
  // sequence
  // ----
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    check(header_on, 1'b0);
    query(CMD_FREQ_QUERY, 2'h0, "1.00000E+3");
    query(CMD_ESE_QUERY, 2'h2, "0");
    foreach (vals[g]) begin
      slow <= g[0];
      pulse(g, vals[g] & 8'hF0);
      pulse(g, vals[g] & 8'h0F);
      query(CMD_ESR_QUERY, g[1:0], txt[g]);
      query(CMD_ESR_QUERY, g[1:0], "0");
    end
    slow <= 1'b0;
    send(CMD_ESE_SET, 2'h1, 32'hFF, 8'sh00);
    pulse(1, 8'h10);
    @(posedge mclk);
    check(event_summary, 4'h2);
    query(CMD_ESE_QUERY, 2'h1, "255");
    e0 = n_err;
    send(CMD_ESE_SET, 2'h1, 32'h9FB, 8'shFF);
    check(n_err - e0, 1);
    query(CMD_ESR_QUERY, 2'h1, "16");
    check(event_summary, 4'h0);
    send(CMD_HEADER_SET, 2'h0, 32'h1, 8'sh00);
    check(header_on, 1'b1);
    query(CMD_ESE_QUERY, 2'h1, ":ESE1 255");
    pulse(3, 8'h20);
    query(CMD_ESR_QUERY, 2'h3, "32");
    query(CMD_FREQ_QUERY, 2'h0, ":FREQUENCY 1.00000E+3");
    send(CMD_HEADER_SET, 2'h0, 32'h0, 8'sh00);
    for (int i = 0; i < 5; i++) begin
      e0 = n_err;
      send(CMD_FREQ_SET, 2'h0, fm[i], fx[i]);
      check(freq_sel, ff[i]);
      check(n_err - e0, fe[i]);
      query(CMD_FREQ_QUERY, 2'h0, ft[i]);
    end
    // mid-run reset must bring back the power-on settings
    send(CMD_HEADER_SET, 2'h0, 32'h1, 8'sh00);
    pulse(1, 8'h01);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    check({freq_sel, header_on, event_summary}, {FREQ_1K, 1'b0, 4'h0});
    query(CMD_ESE_QUERY, 2'h1, "0");
    final_report();
  end
endmodule
